// >>> see_top.sv
// serial nonvolatile memory target: decoder, array, latch, status
// assumes pins arrive asynchronously and core_clk is well above the link clock
// Function
// - serial input bits are taken on rising link clock edges
// - serial output changes only after falling link clock edges
// - chip select high deselects and floats the serial output
// - nothing happens until a first chip select falling edge
// - an 8-bit opcode shifts in from the first rising edge
// - pausing the link clock holds all transfer state
// - opcode 06 sets the write latch, 04 clears it
// - opcode 05 returns the status byte, even while busy
// - opcode 03 takes an address and streams stored bytes out
// - opcode 02 takes an address and one byte to program
// - opcode 01 does nothing
// - a write completes only with the write latch set
// - the write latch is clear after power-on
// - status bits 2 to 7 read as one
// - status bit 0 shows an internal write in progress
// - status bit 1 shows the write latch
// - read address increments as each byte is loaded for sending
// - read address wraps past the top to zero
// - chip select high ends a read and releases the output
// - a write is exactly thirty-two clocks, a thirty-third cancels it
// - finishing a write leaves the write latch set
`timescale 1ns/100ps
`include "see_params.svh"
module see_top #(
   parameter int ADDR_BITS = 10,
   parameter int WRITE_CYCLES = `SEE_TWP_NS / `SEE_CLK_NS
) (
   input wire logic core_clk, // 100 MHz system clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic cs_n, // chip select pin, active low
   input wire logic sck, // serial clock pin
   input wire logic si, // serial data in pin
   output logic so_o, // serial data out value
   output logic so_oe, // serial data out enable
   output logic busy // internal write in progress
);
   import see_pkg::*;

   localparam int TW = $clog2(WRITE_CYCLES + 1);
   localparam logic [TW-1:0] TLAST = TW'(WRITE_CYCLES - 1);

   logic [7:0] mem [0:(1<<ADDR_BITS)-1];
   see_pins_s p1_q, p2_q;
   logic sck_prev_q, cs_prev_q;
   see_state_e st_q, st_d;
   logic armed_q, armed_d, wel_q, wel_d, busy_q, busy_d, rd_q, rd_d;
   logic so_q, so_d, oe_q, oe_d;
   logic [5:0] cnt_q, cnt_d;
   logic [15:0] sh_q, sh_d;
   logic [ADDR_BITS-1:0] addr_q, addr_d;
   logic [7:0] wdat_q, wdat_d, tx_q, tx_d;
   logic [2:0] bcnt_q, bcnt_d;
   logic [TW-1:0] tmr_q, tmr_d;
   logic rise, fall, cs_fall, act, wr_go;
   logic [15:0] nsh;
   logic [7:0] stat_byte, byte_out;

   // pins pass two flops; edge detection reads only the second stage
   // select stages reset low: a select already low at release is no falling edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         p1_q <= '{cs_n: 1'b0, sck: 1'b0, si: 1'b0};
         p2_q <= '{cs_n: 1'b0, sck: 1'b0, si: 1'b0};
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b0;
      end else begin
         p1_q <= '{cs_n: cs_n, sck: sck, si: si};
         p2_q <= p1_q;
         sck_prev_q <= p2_q.sck;
         cs_prev_q <= p2_q.cs_n;
      end
   end

   // edges of the sampled link clock and chip select
   assign rise = p2_q.sck & ~sck_prev_q;
   assign fall = ~p2_q.sck & sck_prev_q;
   assign cs_fall = ~p2_q.cs_n & cs_prev_q;
   assign act = armed_q & ~p2_q.cs_n;
   assign nsh = {sh_q[14:0], p2_q.si};
   assign stat_byte = {`SEE_STAT_ONES, wel_q, busy_q};
   assign byte_out = (st_q == ST_STAT) ? stat_byte : mem[addr_q];

   // next-state logic for the whole transfer engine
   always_comb begin
      st_d = st_q;
      armed_d = armed_q;
      wel_d = wel_q;
      busy_d = busy_q;
      rd_d = rd_q;
      so_d = so_q;
      oe_d = oe_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      addr_d = addr_q;
      wdat_d = wdat_q;
      tx_d = tx_q;
      bcnt_d = bcnt_q;
      tmr_d = tmr_q;
      wr_go = 1'b0;
      // programming timer runs regardless of the link
      if (busy_q) begin
         if (tmr_q == TLAST) begin
            busy_d = 1'b0;
         end else begin
            tmr_d = tmr_q + 1'b1;
         end
      end
      if (cs_fall) begin
         armed_d = 1'b1;
         st_d = ST_OPC;
         cnt_d = '0;
         bcnt_d = '0;
      end else if (p2_q.cs_n) begin
         // deselect: a write counts only if exactly 32 clocks came
         if (armed_q && st_q == ST_WDAT && cnt_q == `SEE_WRITE_BITS && wel_q && !busy_q) begin
            wr_go = 1'b1;
            busy_d = 1'b1;
            tmr_d = '0;
         end
         st_d = ST_OPC;
         cnt_d = '0;
         bcnt_d = '0;
         oe_d = 1'b0;
      end else if (act) begin
         // no edges means nothing moves, so a paused clock holds state
         if (rise) begin
            sh_d = nsh;
            cnt_d = (cnt_q == `SEE_CNT_SAT) ? cnt_q : cnt_q + 1'b1;
            case (st_q)
               ST_OPC: begin
                  if (cnt_q == `SEE_OPC_LAST) begin
                     rd_d = (nsh[7:0] == `SEE_OP_READ);
                     if (busy_q && nsh[7:0] != `SEE_OP_STATUS) begin
                        st_d = ST_IGN;
                     end else if (nsh[7:0] == `SEE_OP_SET_LATCH) begin
                        wel_d = 1'b1;
                        st_d = ST_IGN;
                     end else if (nsh[7:0] == `SEE_OP_CLR_LATCH) begin
                        wel_d = 1'b0;
                        st_d = ST_IGN;
                     end else if (nsh[7:0] == `SEE_OP_STATUS) begin
                        st_d = ST_STAT;
                     end else if (nsh[7:0] == `SEE_OP_READ || nsh[7:0] == `SEE_OP_WRITE) begin
                        st_d = ST_ADDR;
                     end else begin
                        st_d = ST_IGN;
                     end
                  end
               end
               ST_ADDR: begin
                  if (cnt_q == `SEE_ADDR_LAST) begin
                     addr_d = nsh[ADDR_BITS-1:0];
                     st_d = rd_q ? ST_RDAT : ST_WDAT;
                  end
               end
               ST_WDAT: begin
                  if (cnt_q == `SEE_WRITE_LAST) begin
                     wdat_d = nsh[7:0];
                  end
               end
               default: begin
               end
            endcase
         end
         // output bits move only after falling edges
         if (fall && (st_q == ST_STAT || st_q == ST_RDAT)) begin
            oe_d = 1'b1;
            bcnt_d = bcnt_q + 1'b1;
            if (bcnt_q == '0) begin
               so_d = byte_out[7];
               tx_d = {byte_out[6:0], 1'b0};
               if (st_q == ST_RDAT) begin
                  addr_d = addr_q + 1'b1;
               end
            end else begin
               so_d = tx_q[7];
               tx_d = {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // register the transfer engine; latch starts clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_OPC;
         armed_q <= 1'b0;
         wel_q <= 1'b0;
         busy_q <= 1'b0;
         rd_q <= 1'b0;
         so_q <= 1'b0;
         oe_q <= 1'b0;
         cnt_q <= '0;
         sh_q <= '0;
         addr_q <= '0;
         wdat_q <= '0;
         tx_q <= '0;
         bcnt_q <= '0;
         tmr_q <= '0;
      end else begin
         st_q <= st_d;
         armed_q <= armed_d;
         wel_q <= wel_d;
         busy_q <= busy_d;
         rd_q <= rd_d;
         so_q <= so_d;
         oe_q <= oe_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         wdat_q <= wdat_d;
         tx_q <= tx_d;
         bcnt_q <= bcnt_d;
         tmr_q <= tmr_d;
      end
   end

   // array is programmed at write start; the busy timer models the cell time
   always_ff @(posedge core_clk) begin
      if (wr_go) begin
         mem[addr_q] <= wdat_q;
      end
   end

   assign so_o = so_q;
   assign so_oe = oe_q;
   assign busy = busy_q;

   // all checks run on the core clock and sleep through reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   chk_hiz_deselect: assert property (p2_q.cs_n |=> !so_oe)
      else $error("output driven while deselected");
   chk_unarmed_idle: assert property (!armed_q |-> !wel_q && st_q == ST_OPC && cnt_q == '0)
      else $error("activity before first select");
   chk_latch_set: assert property (act && rise && st_q == ST_OPC && cnt_q == `SEE_OPC_LAST && !busy_q
      && nsh[7:0] == `SEE_OP_SET_LATCH |=> wel_q)
      else $error("latch not set");
   chk_status_top: assert property (act && fall && st_q == ST_STAT && bcnt_q == '0 |=> so_q && so_oe)
      else $error("status top bit not one");
   chk_write_gate: assert property (wr_go |-> wel_q && $past(p2_q.cs_n) == 1'b0 && cnt_q == `SEE_WRITE_BITS)
      else $error("write without latch or count");
   chk_busy_start: assert property (wr_go |=> busy && wel_q)
      else $error("busy not raised");
   chk_latch_keep: assert property ($fell(busy_q) |-> wel_q)
      else $error("latch lost at write end");
   chk_busy_ignore: assert property (act && rise && st_q == ST_OPC && cnt_q == `SEE_OPC_LAST && busy_q
      && nsh[7:0] != `SEE_OP_STATUS |=> st_q == ST_IGN && $stable(wel_q))
      else $error("command taken while busy");
   chk_addr_step: assert property (act && fall && st_q == ST_RDAT && bcnt_q == '0
      |=> addr_q == ADDR_BITS'($past(addr_q) + 1'b1))
      else $error("read address did not step");
   chk_out_on_fall: assert property (!fall |=> $stable(so_q))
      else $error("output changed without falling edge");

   // the clear opcode drops the latch at its eighth rising edge
   chk_latch_clear: assert property (act && rise && st_q == ST_OPC && cnt_q == `SEE_OPC_LAST
      && !busy_q && nsh[7:0] == `SEE_OP_CLR_LATCH |=> !wel_q)
      else $error("latch not cleared");
   // a no-op opcode parks the frame and leaves the latch alone
   chk_nop_inert: assert property (act && rise && st_q == ST_OPC && cnt_q == `SEE_OPC_LAST
      && nsh[7:0] == `SEE_OP_NOP |=> st_q == ST_IGN && $stable(wel_q))
      else $error("no-op changed state");
   // status stays reachable during programming
   chk_status_busy: assert property (act && rise && st_q == ST_OPC && cnt_q == `SEE_OPC_LAST
      && busy_q && nsh[7:0] == `SEE_OP_STATUS |=> st_q == ST_STAT)
      else $error("status refused while busy");
   // whole status byte: ones on top, then latch, then busy
   chk_status_bits: assert property (act && fall && st_q == ST_STAT && bcnt_q == '0
      |=> {so_q, tx_q[7:1]} == {`SEE_STAT_ONES, $past(wel_q), $past(busy_q)})
      else $error("status byte wrong");
   // the low address bits land in the read and write pointer
   chk_addr_take: assert property (act && rise && st_q == ST_ADDR && cnt_q == `SEE_ADDR_LAST
      |=> addr_q == ADDR_BITS'($past(nsh)))
      else $error("address not captured");
   // the read pointer rolls from the top byte to zero
   chk_wrap_zero: assert property (act && fall && st_q == ST_RDAT && bcnt_q == '0 && addr_q == '1
      |=> addr_q == '0)
      else $error("read address did not wrap");
   // every selected rising edge is counted once, up to saturation
   chk_edge_count: assert property (act && rise && !cs_fall && cnt_q != `SEE_CNT_SAT
      |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("clock edge miscounted");
   // a deselect always returns the engine to opcode capture
   chk_desel_reset: assert property (p2_q.cs_n |=> st_q == ST_OPC)
      else $error("deselect left a frame open");
   // busy may only drop once the timer has reached its last count
   chk_busy_clear: assert property ($fell(busy_q) |-> $past(tmr_q) == TLAST)
      else $error("busy dropped early");
   // the captured byte reaches the array at the captured address
   chk_write_stored: assert property (wr_go |=> mem[$past(addr_q)] == $past(wdat_q))
      else $error("array not written");
endmodule

// >>> see_params.svh
// constants for the serial nonvolatile memory target
// assumes the includer is compiled after this header, no other dependency
`ifndef SEE_PARAMS_SVH
`define SEE_PARAMS_SVH
`define SEE_OP_SET_LATCH 8'h06
`define SEE_OP_CLR_LATCH 8'h04
`define SEE_OP_STATUS 8'h05
`define SEE_OP_READ 8'h03
`define SEE_OP_WRITE 8'h02
`define SEE_OP_NOP 8'h01
`define SEE_STAT_ONES 6'h3f
`define SEE_STAT_BUSY_BIT 0
`define SEE_STAT_LATCH_BIT 1
`define SEE_OPC_LAST 6'h07
`define SEE_ADDR_LAST 6'h17
`define SEE_WRITE_LAST 6'h1f
`define SEE_WRITE_BITS 6'h20
`define SEE_CNT_SAT 6'h21
`define SEE_TWP_NS 5000000
`define SEE_CLK_NS 10
`endif

// >>> see_pkg.sv
// types shared by the serial nonvolatile memory target
// assumes nothing beyond a SystemVerilog compiler
package see_pkg;
   typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_RDAT, ST_WDAT, ST_STAT, ST_IGN} see_state_e;
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } see_pins_s;
endpackage

// >>> see_master.sv
// bus master partner: drives select, serial clock and data in, mode 0
// assumes core_clk paces every change and so is the resolved output wire
`timescale 1ns/100ps
module see_master (
   input wire logic core_clk, // bench clock
   input wire logic so, // resolved serial output wire
   output see_pkg::see_pins_s pins // select, clock and data to the target
);
   import see_pkg::*;
   // deselected, clock parked low outside frames
   initial begin
      pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
   end
   // a falling select opens every frame, the first one too
   task automatic sel();
      @(negedge core_clk) pins.cs_n = 1'b0;
      repeat (3) @(negedge core_clk);
   endtask
   // msb first, 80 ns per bit; hold parks the clock high to act slow
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int hold = 0, input int nb = 8);
      for (int i = 7; i > 7 - nb; i--) begin
         @(negedge core_clk) pins.si = tx[i];
         repeat (3) @(negedge core_clk);
         pins.sck = 1'b1;
         if (i == 4)
            repeat (hold) @(negedge core_clk);
         repeat (4) @(negedge core_clk);
         rx[i] = so; // late in the bit, output moves only after a fall
         pins.sck = 1'b0;
      end
   endtask
   // raising select ends the operation; gap lets the output float
   task automatic desel();
      @(negedge core_clk) pins.cs_n = 1'b1;
      repeat (6) @(negedge core_clk);
   endtask
endmodule

// >>> test_spi_serial_eeprom_slave.sv
// self-checking bench for the serial nonvolatile memory target
// assumes see_master as bus master and a shortened programming time
`timescale 1ns/100ps
module test_spi_serial_eeprom_slave;
   import see_pkg::*;
   localparam int WCYC = 1000; // long enough to poll status while busy
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic so_o, so_oe, busy, so_w;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   see_pins_s pins;
   see_top #(.WRITE_CYCLES(WCYC)) u_dut (.core_clk(core_clk), .nrst(nrst), .cs_n(pins.cs_n), .sck(pins.sck),
      .si(pins.si), .so_o(so_o), .so_oe(so_oe), .busy(busy));
   see_master u_mst (.core_clk(core_clk), .so(so_w), .pins(pins));
   // released wire shows the inverse of the last bit so a missing enable is caught
   assign so_w = so_oe ? so_o : ~so_o;
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      logic [7:0] rx;
      u_mst.sel();
      u_mst.xfer(op, rx);
      u_mst.desel();
   endtask
   // second byte carries the status, the first is the opcode
   task automatic status(input logic [7:0] exp);
      logic [7:0] rx;
      u_mst.sel();
      u_mst.xfer(8'h05, rx);
      u_mst.xfer(8'hff, rx);
      chk("status", rx, exp);
      u_mst.desel();
   endtask
   // extra adds a thirty-third clock
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit extra);
      logic [7:0] rx;
      u_mst.sel();
      u_mst.xfer(8'h02, rx);
      u_mst.xfer(a[15:8], rx);
      u_mst.xfer(a[7:0], rx);
      u_mst.xfer(d, rx);
      if (extra)
         u_mst.xfer(8'h00, rx, 0, 1);
      u_mst.desel();
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1, input int hold);
      logic [7:0] rx;
      u_mst.sel();
      u_mst.xfer(8'h03, rx);
      u_mst.xfer(a[15:8], rx);
      u_mst.xfer(a[7:0], rx);
      u_mst.xfer(8'h00, rx, hold);
      chk("read byte 0", rx, e0);
      u_mst.xfer(8'h00, rx);
      chk("read byte 1", rx, e1);
      u_mst.desel();
      chk("so_oe after deselect", so_oe, 1'b0);
   endtask
   task automatic settle();
      for (int n = 0; n < WCYC + 200 && busy !== 1'b0; n++)
         @(negedge core_clk);
      chk("busy after programming", busy, 1'b0);
   endtask
   task automatic t_idle();
      chk("so_oe after reset", so_oe, 1'b0);
      status(8'hfc);
      $display("test idle done");
   endtask
   // latch commands, no-op, write refused without the latch
   task automatic t_latch();
      wr(16'h0010, 8'ha5, 1'b0);
      chk("busy without latch", busy, 1'b0);
      cmd(8'h06);
      status(8'hfe);
      cmd(8'h01);
      status(8'hfe);
      cmd(8'h04);
      status(8'hfc);
      $display("test latch done");
   endtask
   // program top and bottom, poll while busy, read across the wrap
   task automatic t_write();
      logic [7:0] rx;
      cmd(8'h06);
      wr(16'hfbff, 8'h5a, 1'b0);
      chk("busy after write", busy, 1'b1);
      status(8'hff);
      cmd(8'h04);
      u_mst.sel();
      u_mst.xfer(8'h03, rx);
      u_mst.xfer(8'h00, rx);
      u_mst.xfer(8'h00, rx);
      u_mst.xfer(8'h00, rx);
      chk("so_oe read while busy", so_oe, 1'b0);
      u_mst.desel();
      settle();
      status(8'hfe);
      wr(16'h0000, 8'hc3, 1'b0);
      settle();
      rd(16'h03ff, 8'h5a, 8'hc3, 40);
      $display("test write done");
   endtask
   task automatic t_long();
      wr(16'h0000, 8'h11, 1'b1);
      chk("busy after 33 clocks", busy, 1'b0);
      rd(16'h83ff, 8'h5a, 8'hc3, 0);
      $display("test long write done");
   endtask
   // reset mid-run with select held low: no fall is seen, so the opcode is ignored
   task automatic t_reset();
      logic [7:0] rx;
      status(8'hfe);
      u_mst.sel();
      @(negedge core_clk) nrst = 1'b0;
      repeat (4) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      u_mst.xfer(8'h06, rx);
      u_mst.desel();
      status(8'hfc);
      $display("test reset done");
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge core_clk);
      nrst = 1'b1;
      repeat (4) @(negedge core_clk);
      t_idle();
      t_latch();
      t_write();
      t_long();
      t_reset();
      stop_test();
   end
endmodule
